/* logic/sar_conversion_sequencer.sv */
// Successive-approximation conversion sequencer with result FIFO
// Functional notes
// RQ1: Start conversion on falling convert start
// RQ2: Open ground switches, then tie arrays
// RQ3: Sixteen binary-weighted trials, MSB first
// RQ4: Last decision forms code, busy drops
// RQ5: Result belongs to its own sample
// RQ6: Fast mode supports one megasample rate; code's shortest cycle is 22 clocks, about 909k
// RQ7: Host keeps fast-mode gaps under 1ms
// RQ8: Host discards first result after gap
// RQ9: Normal mode, no gap limit, 800k; code's shortest cycle is 26 clocks, about 769k
// RQ10: Low power between conversions, 666k max
// RQ11: Coding select picks binary or two's
// RQ12: Falling edge enters hold and converts
// RQ13: Low-power mode auto-restarts if held low
// RQ14: Sleep finishes conversion then inhibits
// RQ15: Busy high from start until code valid
`timescale 1ns/1ps
module sar_conversion_sequencer
   import sar_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic        sys_clk_i,            // System clock, 20 MHz
   input  wire logic        rstn_i,               // Synchronous reset, active low
   input  wire logic        convert_start_n_i,    // Convert start, active low
   input  wire logic        fast_mode_i,          // Fastest throughput mode
   input  wire logic        low_power_mode_i,     // Low-power throughput mode
   input  wire logic        output_coding_select_i, // 1 straight binary, 0 two's complement
   input  wire logic        sleep_request_i,      // Sleep request, active high
   input  wire logic        comparator_i,         // 1 keeps element under test
   output sar_pkg::switch_ctl_t switch_ctl_o,     // Analog switch controls
   output logic             busy_o,               // Conversion in progress
   output logic             power_save_o,         // Analog bias reduced
   output logic [15:0]      result_data_o,        // Result code
   output logic             result_valid_o,       // Result available
   input  wire logic        result_ready_i,       // Reader takes result
   output logic             overrun_o             // Result dropped, FIFO full
);
   import sar_pkg::*;

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("FIFO_DEPTH too small");
   end

   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   typedef struct packed {
      seq_state_t          st;
      logic [CNT_W-1:0]    cnt;
      logic [4:0]          bitn;
      logic [15:0]         trial;
      logic [15:0]         code;
      logic                cs_q;
      logic                push;
      logic                overrun;
      logic                armed;
   } seq_regs_t;

   seq_regs_t        r;
   seq_regs_t        next_r;
   seq_mode_t        mode;
   logic [15:0]      bit_onehot;
   logic [15:0]      decided;
   logic             fall;
   logic             fifo_ready;
   logic [CNT_W-1:0] acq_len;

   assign mode = fast_mode_i ? MODE_FAST : (low_power_mode_i ? MODE_LOWP : MODE_NORMAL);
   assign fall = r.cs_q && !convert_start_n_i;
   assign bit_onehot = 16'h0001 << r.bitn[3:0];

   // Acquisition length per mode sets throughput
   always_comb begin
      case (mode)
         MODE_FAST:   acq_len = CNT_W'(ACQ_FAST_CYC); // RQ6
         MODE_LOWP:   acq_len = CNT_W'(ACQ_LOWP_CYC); // RQ10
         default:     acq_len = CNT_W'(ACQ_NORM_CYC); // RQ9
      endcase
   end

   sar_step #(
      .W        (RES_BITS)
   ) u_step (
      .trial_i  (r.trial),
      .bit_i    (bit_onehot),
      .keep_i   (comparator_i),
      .result_o (decided)
   );

   // ----------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------
   always_comb begin
      next_r      = r;
      next_r.cs_q = convert_start_n_i;
      next_r.push = 1'b0;
      if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
      case (r.st)
         ST_ACQ: begin
            if (r.cnt != '0) begin
               // Acquisition still running; a falling edge waits only in low-power mode
               if (fall && mode == MODE_LOWP) begin
                  next_r.armed = 1'b1;
               end
            end else if (sleep_request_i) begin
               next_r.st = ST_SLEEP; // RQ14
            end else if (fall || r.armed ||
                         (mode == MODE_LOWP && !convert_start_n_i && !r.cs_q)) begin // RQ1 RQ12 RQ13
               next_r.st    = ST_SWOPEN;
               next_r.cnt   = CNT_W'(SWOPEN_CYC - 1);
               next_r.armed = 1'b0;
            end
         end
         ST_SWOPEN: begin
            if (r.cnt == '0) begin
               next_r.st  = ST_TIE; // RQ2
               next_r.cnt = CNT_W'(TIE_CYC - 1);
            end
         end
         ST_TIE: begin
            if (r.cnt == '0) begin
               next_r.st    = ST_BIT;
               next_r.bitn  = 5'd15; // RQ3
               next_r.trial = SIGN_FLIP;
               next_r.cnt   = CNT_W'(BIT_CYC - 1);
            end
         end
         ST_BIT: begin
            if (r.cnt == '0) begin
               if (r.bitn == 5'd0) begin
                  next_r.trial = decided;
                  next_r.st    = ST_DONE;
               end else begin
                  next_r.trial = decided | (bit_onehot >> 1); // RQ3
                  next_r.bitn  = r.bitn - 1'b1;
                  next_r.cnt   = CNT_W'(BIT_CYC - 1);
               end
            end
         end
         ST_DONE: begin
            // Form output code from this conversion's own trial word
            next_r.code = output_coding_select_i ? r.trial : (r.trial ^ SIGN_FLIP); // RQ4 RQ5 RQ11
            next_r.push = 1'b1;
            next_r.st   = ST_ACQ;
            next_r.cnt  = acq_len;
            if (!fifo_ready) begin
               next_r.overrun = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (!sleep_request_i) begin
               next_r.st  = ST_ACQ;
               next_r.cnt = acq_len;
            end
         end
         default: begin
            next_r.st = ST_ACQ;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         r <= '{st: ST_ACQ, cnt: '0, bitn: 5'd0, trial: CODE_RESET, code: CODE_RESET,
                cs_q: 1'b1, push: 1'b0, overrun: 1'b0, armed: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign busy_o = (r.st == ST_SWOPEN) || (r.st == ST_TIE) || (r.st == ST_BIT) || (r.st == ST_DONE); // RQ15
   assign power_save_o = (r.st == ST_SLEEP) || (r.st == ST_ACQ && mode == MODE_LOWP); // RQ10 RQ14
   assign overrun_o = r.overrun;

   always_comb begin
      switch_ctl_o = '0;
      switch_ctl_o.pos_ground_switch = (r.st == ST_ACQ) || (r.st == ST_SLEEP);
      switch_ctl_o.neg_ground_switch = switch_ctl_o.pos_ground_switch;
      switch_ctl_o.track             = (r.st == ST_ACQ) || (r.st == ST_SLEEP) || (r.st == ST_SWOPEN); // RQ2
      switch_ctl_o.reference_ground  = (r.st == ST_TIE) || (r.st == ST_BIT) || (r.st == ST_DONE);
      switch_ctl_o.dac_bits          = (r.st == ST_BIT) ? r.trial : 16'h0000;
   end

   sync_fifo #(
      .WIDTH       (RES_BITS),
      .DEPTH       (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .in_data_i   (r.code),
      .in_valid_i  (r.push),
      .in_ready_o  (fifo_ready),
      .out_data_o  (result_data_o),
      .out_valid_o (result_valid_o),
      .out_ready_i (result_ready_i)
   );

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   sequence s_start;
      r.st == ST_ACQ && r.cnt == '0 && !sleep_request_i && fall;
   endsequence
   sequence s_open_then_tie;
      r.st == ST_SWOPEN ##1 r.st == ST_TIE;
   endsequence

   a_start_edge: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_start |=> busy_o) else $error("no start on falling edge"); // RQ1
   a_switch_order: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_start |=> s_open_then_tie) else $error("switch order wrong"); // RQ2
   a_ground_open: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      switch_ctl_o.reference_ground |-> !switch_ctl_o.pos_ground_switch && !switch_ctl_o.track)
      else $error("arrays tied while tracking"); // RQ2
   a_msb_first: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(r.st == ST_BIT) |-> r.bitn == 5'd15 && r.trial == 16'h8000) else $error("msb not first"); // RQ3
   a_conv_length: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(r.st == ST_BIT) |-> ##16 r.st == ST_DONE ##1 !busy_o) else $error("bad length"); // RQ4
   a_result_push: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      r.st == ST_DONE |=> r.push &&
         r.code == ($past(output_coding_select_i) ? $past(r.trial) : ($past(r.trial) ^ 16'h8000)))
      else $error("code not formed"); // RQ5
   a_coding_sel: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      r.st == ST_DONE && !output_coding_select_i |=> r.code[15] == !$past(r.trial[15]))
      else $error("coding select ignored"); // RQ11
   a_sleep_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      r.st == ST_SLEEP && sleep_request_i |=> !busy_o && power_save_o) else $error("sleep started conversion"); // RQ14
   a_busy_steady: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(busy_o) |-> busy_o [*2]) else $error("busy glitch"); // RQ15
endmodule

/* logic/sar_pkg.sv */
// Shared constants and carriers for the successive-approximation sequencer
package sar_pkg;
   localparam int          RES_BITS      = 16;
   localparam int          CLK_HZ        = 20000000;
   localparam int          CLK_PERIOD_PS = 50000;
   // Phase lengths in ns, converted to cycles (least times round up)
   localparam int          T_SWOPEN_NS   = 50;
   localparam int          T_TIE_NS      = 50;
   localparam int          T_BIT_NS      = 50;
   localparam int          T_ACQ_FAST_NS = 100;
   localparam int          T_ACQ_NORM_NS = 300;
   localparam int          T_ACQ_LOWP_NS = 500;
   localparam int          SWOPEN_CYC    = (T_SWOPEN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          TIE_CYC       = (T_TIE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          BIT_CYC       = (T_BIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          ACQ_FAST_CYC  = (T_ACQ_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          ACQ_NORM_CYC  = (T_ACQ_NORM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          ACQ_LOWP_CYC  = (T_ACQ_LOWP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          CNT_W         = 8;
   localparam logic [15:0] CODE_RESET    = 16'h0000;
   localparam logic [15:0] SIGN_FLIP     = 16'h8000;

   typedef enum logic [2:0] {
      ST_ACQ    = 3'b000,
      ST_SWOPEN = 3'b001,
      ST_TIE    = 3'b010,
      ST_BIT    = 3'b011,
      ST_DONE   = 3'b100,
      ST_SLEEP  = 3'b101
   } seq_state_t;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_FAST   = 2'b01,
      MODE_LOWP   = 2'b10
   } seq_mode_t;

   // Analog switch controls
   typedef struct packed {
      logic        pos_ground_switch; // Comparator + input tied to ground
      logic        neg_ground_switch; // Comparator - input tied to ground
      logic        track;             // Arrays connected to the analog inputs
      logic        reference_ground;  // Arrays connected to reference ground
      logic [15:0] dac_bits;          // Element to reference (1) or ground (0)
   } switch_ctl_t;
endpackage

/* logic/sar_step.sv */
// One successive-approximation bit decision
`timescale 1ns/1ps
module sar_step #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] trial_i,    // Bits kept so far
   input  wire logic [W-1:0] bit_i,      // One-hot element under test
   input  wire logic         keep_i,     // Comparator says keep element
   output logic [W-1:0]      result_o    // Bits after the decision
);
   always_comb begin
      result_o = keep_i ? trial_i : (trial_i & ~bit_i);
   end
endmodule

/* logic/sync_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk_i, // System clock
   input  wire logic             rstn_i,    // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] in_data_i, // Write data
   input  wire logic             in_valid_i,// Write request
   output logic                  in_ready_o,// Room available
   output logic [WIDTH-1:0]      out_data_o,// Read data
   output logic                  out_valid_o,// Data available
   input  wire logic             out_ready_i // Reader takes data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr;
   logic [AW:0]      rptr;
   logic             wr;
   logic             rd;
   assign in_ready_o  = (wptr - rptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wptr != rptr;
   assign out_data_o  = mem[rptr[AW-1:0]];
   assign wr          = in_valid_i && in_ready_o;
   assign rd          = out_valid_o && out_ready_i;
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (wr) begin
            wptr <= wptr + 1'b1;
         end
         if (rd) begin
            rptr <= rptr + 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (wr) begin
         mem[wptr[AW-1:0]] <= in_data_i;
      end
   end
   a_fifo_no_overflow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (wptr - rptr) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule

/* sim/analog_front_model.sv */
// Behavioural sampling arrays and comparator facing the sequencer
`timescale 1ns/1ps
module analog_front_model (
   input  wire logic                 sys_clk_i,    // System clock
   input  wire logic [15:0]          sample_i,     // Differential input as a code
   input  wire sar_pkg::switch_ctl_t switch_ctl_i, // Switch controls from the sequencer
   output logic                      comparator_o  // 1 keeps element under test
);
   import sar_pkg::*;

   logic [15:0] held;

   // Arrays follow the input while tracking and freeze once switched away
   always_ff @(posedge sys_clk_i) begin
      if (switch_ctl_i.track) begin
         held <= sample_i;
      end
   end

   // Comparator stays balanced while the trial does not exceed the held value
   assign comparator_o = (switch_ctl_i.dac_bits <= held);
endmodule

/* sim/test_sar_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_sar_conversion_sequencer;
   import sar_pkg::*;

   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        convert_start_n = 1'b1;
   logic        fast_mode = 1'b0;
   logic        low_power_mode = 1'b0;
   logic        coding = 1'b1;
   logic        sleep_request = 1'b0;
   logic        result_ready = 1'b0;
   logic [15:0] sample = 16'h0000;
   logic        comparator;
   switch_ctl_t switch_ctl;
   logic        busy;
   logic        power_save;
   logic        result_valid;
   logic        overrun;
   logic [15:0] result_data;
   int          errors = 0;
   int          n_checks = 0;
   int          busy_len;
   logic [15:0] vals [6] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'ha5c3, 16'h0001};

   always #25 sys_clk = ~sys_clk;

   sar_conversion_sequencer #(.FIFO_DEPTH(8)) dut (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .convert_start_n_i(convert_start_n), .fast_mode_i(fast_mode),
      .low_power_mode_i(low_power_mode), .output_coding_select_i(coding), .sleep_request_i(sleep_request),
      .comparator_i(comparator), .switch_ctl_o(switch_ctl), .busy_o(busy), .power_save_o(power_save),
      .result_data_o(result_data), .result_valid_o(result_valid), .result_ready_i(result_ready),
      .overrun_o(overrun));

   analog_front_model model (.sys_clk_i(sys_clk), .sample_i(sample), .switch_ctl_i(switch_ctl),
                             .comparator_o(comparator));

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic wait_busy(input logic level, input int limit);
      int k;
      k = 0;
      while (busy !== level && k < limit) begin
         step(1);
         k++;
      end
      if (busy !== level) begin
         errors++;
         $display("CHECK FAILED busy wait expected %b seen %b", level, busy);
         complete_run();
      end
   endtask

   // One conversion: the input moves once the arrays are held
   task automatic convert(input logic [15:0] s, input logic hold_low, input logic sleep_mid);
      sample = s;
      convert_start_n = 1'b0;
      wait_busy(1'b1, 4);
      check("grounds open first", {switch_ctl.pos_ground_switch, switch_ctl.neg_ground_switch,
            switch_ctl.track}, 32'h1);
      convert_start_n = ~hold_low;
      sleep_request = sleep_mid;
      step(1);
      check("arrays on reference ground", {switch_ctl.reference_ground, switch_ctl.track}, 32'h2);
      sample = ~s;
      step(1);
      check("first trial element", switch_ctl.dac_bits, 32'h8000);
      busy_len = 2;
      while (busy === 1'b1 && busy_len < 40) begin
         step(1);
         busy_len++;
      end
      check("busy length", busy_len, 32'd19);
   endtask

   task automatic read_result(input logic [15:0] exp);
      int k;
      k = 0;
      while (result_valid !== 1'b1 && k < 4) begin
         step(1);
         k++;
      end
      check("result valid", result_valid, 32'h1);
      check("result word", result_data, exp);
      result_ready = 1'b1;
      step(1);
      result_ready = 1'b0;
      step(1);
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      #5;
      rstn = 1'b1;
      check("idle busy", busy, 32'h0);
      check("idle switches", {switch_ctl.pos_ground_switch, switch_ctl.neg_ground_switch, switch_ctl.track,
            switch_ctl.reference_ground}, 32'he);
      check("idle result", result_valid, 32'h0);
      step(2);
      for (int m = 0; m < 3; m++) begin
         for (int c = 0; c < 2; c++) begin
            fast_mode = (m == 1);
            low_power_mode = (m == 2);
            coding = c[0];
            convert(vals[m * 2 + c], 1'b0, 1'b0);
            read_result(coding ? vals[m * 2 + c] : vals[m * 2 + c] ^ SIGN_FLIP);
            check("acquire power save", power_save, {31'h0, low_power_mode});
            step(12);
         end
         $display("Mode and coding test %0d done", m);
      end
      fast_mode = 1'b0;
      low_power_mode = 1'b0;
      coding = 1'b1;
      convert(16'h4321, 1'b0, 1'b0);
      convert_start_n = 1'b0;
      step(10);
      check("early start refused", busy, 32'h0);
      convert_start_n = 1'b1;
      read_result(16'h4321);
      step(8);
      $display("Early start test done");
      convert(16'h0f0f, 1'b0, 1'b1);
      read_result(16'h0f0f);
      step(4);
      check("sleep power save", power_save, 32'h1);
      convert_start_n = 1'b0;
      step(30);
      check("sleep blocks start", busy, 32'h0);
      sleep_request = 1'b0;
      convert_start_n = 1'b1;
      step(12);
      $display("Sleep test done");
      low_power_mode = 1'b1;
      convert(16'h2222, 1'b1, 1'b0);
      wait_busy(1'b1, ACQ_LOWP_CYC + 4);
      check("auto restart", busy, 32'h1);
      convert_start_n = 1'b1;
      wait_busy(1'b0, 30);
      read_result(16'h2222);
      read_result(~16'h2222);
      step(12);
      $display("Auto restart test done");
      low_power_mode = 1'b0;
      fast_mode = 1'b1;
      // Fast-mode starts come back to back, far inside the gap limit; the model has no settling loss to discard
      for (int i = 0; i < 8; i++) begin
         convert(16'h1111 * 16'(i), 1'b0, 1'b0);
         step(4);
      end
      check("no overrun yet", overrun, 32'h0);
      convert(16'hbeef, 1'b0, 1'b0);
      step(4);
      check("overrun flag", overrun, 32'h1);
      for (int i = 0; i < 8; i++) begin
         read_result(16'h1111 * 16'(i));
      end
      check("drained", result_valid, 32'h0);
      $display("Buffer test done");
      complete_run();
   end
endmodule
